// [floppy_port_pkg.sv]
// Purpose: shared constants and types of the floppy host register port
// Assumes: 16-bit host i/o address, 8-bit host data
// Notes:   one-byte registers; status and data share the host data path
// ****************************************************************
// package
// ****************************************************************
package floppy_port_pkg;

  // host i/o addresses
  localparam logic [15:0] ADDR_STATUS_RATE = 16'h03f4; // status read, rate select write
  localparam logic [15:0] ADDR_DATA        = 16'h03f5;
  localparam logic [15:0] ADDR_INPUT_CTRL  = 16'h03f7; // input port read, control port write

  // controller_status_port field positions
  localparam int MSR_BUSY_LO  = 0;
  localparam int MSR_CMD_BUSY = 4;
  localparam int MSR_POLLED   = 5;
  localparam int MSR_DIR      = 6;
  localparam int MSR_RQM      = 7;

  // disk_input_port and rate_control_port field positions
  localparam int DIR_CHANGE_BIT = 7;
  localparam int CTRL_SKIP_BIT  = 2;
  localparam logic [3:0] DIR_FILL_ONES = 4'hf;

  // values after hardware reset
  localparam logic [1:0] RATE_HW_RESET    = 2'h2; // 250 kbps
  localparam logic       DENSITY_HW_RESET = 1'h1;
  localparam logic       SKIP_HW_RESET    = 1'h0;

  // rate codes that mean high density
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_1M   = 2'h3;

  // register layout selection
  typedef enum logic [1:0] {
    LAYOUT_AT,
    LAYOUT_DUAL,
    LAYOUT_M30
  } layout_t;

  // host-visible phase of a command
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_COMMAND,
    PH_EXEC,
    PH_RESULT
  } phase_t;

endpackage : floppy_port_pkg

// [byte_buffer2.sv]
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: flush is not issued while a push is expected
// Notes:   one_deep limits it to one entry for byte-by-byte pacing
// ****************************************************************
// two-entry buffer
// ****************************************************************
module byte_buffer2
  import floppy_port_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // control
  input  wire logic       flush,
  input  wire logic       one_deep,
  // filling side
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  // draining side
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready
);

  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic       v0;
    logic       v1;
    logic       rdy;
  } buf_state_t;

  buf_state_t st_r;
  buf_state_t st_nxt;
  logic       push;
  logic       pop;

  // entry 0 is always the head, so the read data come straight from a flop
  always_comb begin
    st_nxt = st_r;
    push   = in_valid && st_r.rdy;
    pop    = out_ready && st_r.v0;
    if (pop) begin
      st_nxt.d0 = st_r.d1;
      st_nxt.v0 = st_r.v1;
      st_nxt.v1 = 1'b0;
    end
    if (push) begin
      if (!st_nxt.v0) begin
        st_nxt.d0 = in_data;
        st_nxt.v0 = 1'b1;
      end else begin
        st_nxt.d1 = in_data;
        st_nxt.v1 = 1'b1;
      end
    end
    if (flush) begin
      st_nxt.v0 = 1'b0;
      st_nxt.v1 = 1'b0;
    end
    st_nxt.rdy = one_deep ? !st_nxt.v0 : !st_nxt.v1; // honest full
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '{d0: 8'h00, d1: 8'h00, v0: 1'b0, v1: 1'b0, rdy: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready  = st_r.rdy;
  assign out_valid = st_r.v0;
  assign out_data  = st_r.d0;

endmodule : byte_buffer2

// [floppy_host_register_port.sv]
// Purpose: host register port of a floppy controller: status, data, input and control ports
// Assumes: host strobes and core handshakes are synchronous to mclk
// Notes:   the command engine sits behind the cmd/res byte streams
// ****************************************************************
// top module
// ****************************************************************
module floppy_host_register_port
  import floppy_port_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  // host i/o bus
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd_stb,
  input  wire logic        io_wr_stb,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_oe_lo,
  output logic             io_oe_hi,
  // configuration and neighbours
  input  layout_t          reg_layout,
  input  wire logic        force_change,
  input  wire logic        dma_gate,
  input  wire logic        media_changed_n,
  // command engine status
  input  wire logic [3:0]  drive_seek_active,
  input  wire logic        polled_mode,
  input  wire logic        fifo_enable_set,
  input  wire logic        cmd_end,
  input  wire logic        cmd_has_exec,
  input  wire logic        cmd_has_result,
  input  wire logic        exec_dir_read,
  input  wire logic        exec_end,
  input  wire logic        xfer_overrun,
  input  wire logic        result_end,
  // bytes toward the command engine
  output logic             cmd_valid,
  output logic      [7:0]  cmd_data,
  input  wire logic        cmd_ready,
  // bytes from the command engine
  input  wire logic        res_valid,
  input  wire logic [7:0]  res_data,
  output logic             res_ready,
  // drive side and engine controls
  output logic      [1:0]  rate_select,
  output logic             skip_write_comp,
  output logic             density_out,
  output logic             xfer_abort
);

  typedef struct packed {
    phase_t     phase;
    logic [7:0] controller_status_port;
    logic [1:0] rate;
    logic       skip;
    logic       dens;
    logic       fifo_on;
    logic       abort;
    logic       res_done;
    logic       chg_s1;
    logic       chg_s2;
    logic       chg_s3;
    logic       chg_lvl;
    logic [7:0] rdata;
    logic       oe_lo;
    logic       oe_hi;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;

  // buffer hookup
  logic       wr_push;
  logic       wr_rdy;
  logic       rd_pop;
  logic       rd_valid;
  logic [7:0] rd_head;
  logic       flush_wr;
  logic       flush_rd;
  logic       one_deep;
  logic       rd_in_valid;

  // decode and pacing
  logic       rqm_c;
  logic       dio_c;
  logic       sel_status;
  logic       sel_data;
  logic       sel_inctl;
  logic       chg_bit;
  logic [1:0] rate_new;
  logic       rate_wr;

  // ****************************************************************
  // byte buffers
  // ****************************************************************
  // host to engine: command parameters and disk write data
  byte_buffer2 u_wr_buf (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (flush_wr),
    .one_deep  (one_deep),
    .in_valid  (wr_push),
    .in_data   (io_wdata),
    .in_ready  (wr_rdy),
    .out_valid (cmd_valid),
    .out_data  (cmd_data),
    .out_ready (cmd_ready)
  );

  // engine to host: disk read data and result bytes
  byte_buffer2 u_rd_buf (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (flush_rd),
    .one_deep  (one_deep),
    .in_valid  (rd_in_valid),
    .in_data   (res_data),
    .in_ready  (res_ready),
    .out_valid (rd_valid),
    .out_data  (rd_head),
    .out_ready (rd_pop)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  // one process for the whole port; buffer controls fall out of it
  always_comb begin
    st_nxt     = st_r;
    sel_status = (io_addr == ADDR_STATUS_RATE);
    sel_data   = (io_addr == ADDR_DATA);
    sel_inctl  = (io_addr == ADDR_INPUT_CTRL);
    flush_wr   = 1'b0;
    flush_rd   = 1'b0;
    rqm_c      = 1'b0;
    dio_c      = 1'b0;
    // full depth only in execution with the fifo enabled
    one_deep    = !(st_r.fifo_on && st_r.phase == PH_EXEC);
    rd_in_valid = res_valid && !st_r.abort;

    // request and direction for the current phase
    case (st_r.phase)
      PH_IDLE, PH_COMMAND: begin
        rqm_c = !cmd_valid && wr_rdy;
        dio_c = 1'b0;
      end
      PH_EXEC: begin
        if (st_r.abort) begin
          rqm_c = exec_dir_read && rd_valid;
          dio_c = exec_dir_read;
        end else if (exec_dir_read) begin
          rqm_c = rd_valid;
          dio_c = 1'b1;
        end else begin
          rqm_c = wr_rdy;
          dio_c = 1'b0;
        end
      end
      PH_RESULT: begin
        rqm_c = rd_valid;
        dio_c = 1'b1;
      end
      default: begin
        rqm_c = 1'b0;
        dio_c = 1'b0;
      end
    endcase

    // data port moves a byte only while the request stands
    wr_push = io_wr_stb && sel_data && rqm_c && !dio_c && st_r.phase != PH_RESULT;
    rd_pop  = io_rd_stb && sel_data && rqm_c && dio_c;

    // phase sequencing
    case (st_r.phase)
      PH_IDLE: begin
        if (wr_push) begin
          st_nxt.phase = PH_COMMAND;
        end
      end
      PH_COMMAND: begin
        if (cmd_end) begin
          if (cmd_has_exec) begin
            st_nxt.phase = PH_EXEC;
            flush_wr     = 1'b1;
            flush_rd     = 1'b1;
          end else if (cmd_has_result) begin
            st_nxt.phase = PH_RESULT;
          end else begin
            st_nxt.phase = PH_IDLE;
          end
        end
      end
      PH_EXEC: begin
        if (xfer_overrun) begin
          st_nxt.abort = 1'b1;
          flush_wr     = 1'b1; // stop feeding write data; engine pads the sector
        end
        if (exec_end) begin
          st_nxt.phase = PH_RESULT; // leftover read bytes drain ahead of the results
          st_nxt.abort = 1'b0;
        end
      end
      PH_RESULT: begin
        if (result_end) begin
          st_nxt.res_done = 1'b1;
        end
        if (st_r.res_done && !rd_valid) begin
          st_nxt.phase    = PH_IDLE;
          st_nxt.res_done = 1'b0;
        end
      end
      default: begin
        st_nxt.phase = PH_IDLE;
      end
    endcase

    // fifo mode is turned on only by the configure command
    if (fifo_enable_set) begin
      st_nxt.fifo_on = 1'b1;
    end

    // status byte as the host sees it
    st_nxt.controller_status_port[MSR_BUSY_LO +: 4] = drive_seek_active;
    st_nxt.controller_status_port[MSR_CMD_BUSY]     = (st_nxt.phase != PH_IDLE);
    st_nxt.controller_status_port[MSR_POLLED]       = (st_nxt.phase == PH_EXEC) && polled_mode;
    st_nxt.controller_status_port[MSR_DIR]          = dio_c;
    st_nxt.controller_status_port[MSR_RQM]          = rqm_c;

    // disk change pin: three stages, change accepted when the last two agree
    st_nxt.chg_s1 = media_changed_n;
    st_nxt.chg_s2 = st_r.chg_s1;
    st_nxt.chg_s3 = st_r.chg_s2;
    if (st_r.chg_s2 == st_r.chg_s3) begin
      st_nxt.chg_lvl = st_r.chg_s3;
    end
    chg_bit = !st_r.chg_lvl || force_change;

    // rate writes: newest write of either port wins
    rate_wr  = io_wr_stb && (sel_status || sel_inctl);
    rate_new = io_wdata[1:0];
    if (rate_wr) begin
      st_nxt.rate = rate_new;
      st_nxt.dens = (rate_new == RATE_500K) || (rate_new == RATE_1M);
    end
    // skip bit is written only in the model 30 layout and drives skip_write_comp
    if (io_wr_stb && sel_inctl && reg_layout == LAYOUT_M30) begin
      st_nxt.skip = io_wdata[CTRL_SKIP_BIT];
    end

    // read answer, one cycle after the strobe
    st_nxt.rdata = 8'h00;
    st_nxt.oe_lo = 1'b0;
    st_nxt.oe_hi = 1'b0;
    if (io_rd_stb) begin
      if (sel_status) begin
        st_nxt.rdata = st_r.controller_status_port;
        st_nxt.oe_lo = 1'b1;
        st_nxt.oe_hi = 1'b1;
      end else if (sel_data) begin
        st_nxt.rdata = rd_pop ? rd_head : 8'h00;
        st_nxt.oe_lo = 1'b1;
        st_nxt.oe_hi = 1'b1;
      end else if (sel_inctl) begin
        case (reg_layout)
          LAYOUT_AT: begin
            st_nxt.rdata = {chg_bit, 7'h00};
            st_nxt.oe_hi = 1'b1;
          end
          LAYOUT_DUAL: begin
            // low bit follows the rate code, not the density pin, which is high after reset at 250k
            st_nxt.rdata = {chg_bit, DIR_FILL_ONES, st_r.rate,
                            !((st_r.rate == RATE_500K) || (st_r.rate == RATE_1M))};
            st_nxt.oe_lo = 1'b1;
            st_nxt.oe_hi = 1'b1;
          end
          LAYOUT_M30: begin
            st_nxt.rdata = {chg_bit, 3'h0, dma_gate, st_r.skip, st_r.rate};
            st_nxt.oe_lo = 1'b1;
            st_nxt.oe_hi = 1'b1;
          end
          default: begin
            st_nxt.rdata = 8'h00;
          end
        endcase
      end
    end

    // soft reset clears sequencing but keeps rate, skip and density
    if (soft_rst) begin
      st_nxt.phase    = PH_IDLE;
      st_nxt.fifo_on  = 1'b0;
      st_nxt.abort    = 1'b0;
      st_nxt.res_done = 1'b0;
      st_nxt.controller_status_port      = 8'h00;
      flush_wr        = 1'b1;
      flush_rd        = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // hardware reset: rate 250k, density high, fifo off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '{phase: PH_IDLE, controller_status_port: 8'h00, rate: RATE_HW_RESET, skip: SKIP_HW_RESET,
                dens: DENSITY_HW_RESET, fifo_on: 1'b0, abort: 1'b0, res_done: 1'b0,
                chg_s1: 1'b1, chg_s2: 1'b1, chg_s3: 1'b1, chg_lvl: 1'b1,
                rdata: 8'h00, oe_lo: 1'b0, oe_hi: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata        = st_r.rdata;
  assign io_oe_lo        = st_r.oe_lo;
  assign io_oe_hi        = st_r.oe_hi;
  assign rate_select     = st_r.rate;
  assign skip_write_comp = st_r.skip;
  assign density_out     = st_r.dens;
  assign xfer_abort      = st_r.abort;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_seek_bits;
    (!soft_rst) |=> (st_r.controller_status_port[3:0] == $past(drive_seek_active));
  endproperty
  a_seek_bits: assert property (p_seek_bits) else $error("seek bits do not follow drives");

  property p_busy_first_byte;
    (st_r.phase == PH_IDLE && wr_push && !soft_rst) |=> st_r.controller_status_port[MSR_CMD_BUSY];
  endproperty
  a_busy_first_byte: assert property (p_busy_first_byte) else $error("busy not set by first byte");

  property p_polled_exec;
    (st_r.phase == PH_EXEC && polled_mode && !soft_rst && !exec_end) |=> st_r.controller_status_port[MSR_POLLED];
  endproperty
  a_polled_exec: assert property (p_polled_exec) else $error("polled flag missing in execution");

  property p_result_reads;
    ($past(st_r.phase) == PH_RESULT && st_r.controller_status_port[MSR_RQM]) |-> st_r.controller_status_port[MSR_DIR];
  endproperty
  a_result_reads: assert property (p_result_reads) else $error("result phase not read direction");

  property p_at_oe;
    (io_rd_stb && io_addr == ADDR_INPUT_CTRL && reg_layout == LAYOUT_AT) |=> (io_oe_hi && !io_oe_lo);
  endproperty
  a_at_oe: assert property (p_at_oe) else $error("low data lines driven in first layout");

  property p_change_bit;
    (io_rd_stb && io_addr == ADDR_INPUT_CTRL && reg_layout != LAYOUT_AT)
      |=> (io_rdata[DIR_CHANGE_BIT] == ($past(!st_r.chg_lvl) || $past(force_change)));
  endproperty
  a_change_bit: assert property (p_change_bit) else $error("change bit wrong");

  property p_dual_layout;
    (io_rd_stb && io_addr == ADDR_INPUT_CTRL && reg_layout == LAYOUT_DUAL)
      |=> (io_rdata[6:3] == 4'hf && io_rdata[2:1] == $past(rate_select)
           && io_rdata[0] == !($past(rate_select) == RATE_500K || $past(rate_select) == RATE_1M));
  endproperty
  a_dual_layout: assert property (p_dual_layout) else $error("second layout input byte wrong");

  property p_m30_layout;
    (io_rd_stb && io_addr == ADDR_INPUT_CTRL && reg_layout == LAYOUT_M30)
      |=> (io_rdata[6:4] == 3'h0 && io_rdata[2] == skip_write_comp && io_rdata[3] == $past(dma_gate));
  endproperty
  a_m30_layout: assert property (p_m30_layout) else $error("model 30 input byte wrong");

  property p_rate_write;
    (io_wr_stb && (io_addr == ADDR_INPUT_CTRL || io_addr == ADDR_STATUS_RATE))
      |=> (rate_select == $past(io_wdata[1:0]));
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("newest rate write lost");

  property p_soft_keeps;
    (soft_rst && !io_wr_stb) |=> ($stable(rate_select) && $stable(skip_write_comp) && $stable(density_out));
  endproperty
  a_soft_keeps: assert property (p_soft_keeps) else $error("soft reset disturbed rate settings");

  property p_hw_defaults;
    $fell(rst) |-> (rate_select == RATE_HW_RESET && density_out);
  endproperty
  a_hw_defaults: assert property (p_hw_defaults) else $error("hardware reset defaults wrong");

  property p_fifo_off;
    soft_rst |=> (!st_r.fifo_on && st_r.phase == PH_IDLE);
  endproperty
  a_fifo_off: assert property (p_fifo_off) else $error("fifo left on after reset");

  property p_exec_flush;
    (st_r.phase == PH_COMMAND && cmd_end && cmd_has_exec && !soft_rst) |=> (!cmd_valid && !rd_valid);
  endproperty
  a_exec_flush: assert property (p_exec_flush) else $error("buffers not emptied entering execution");

  property p_overrun_stop;
    (st_r.phase == PH_EXEC && xfer_overrun && !exec_end && !soft_rst) |=> (xfer_abort && !cmd_valid);
  endproperty
  a_overrun_stop: assert property (p_overrun_stop) else $error("overrun did not stop transfer");

  c_command: cover property (st_r.phase == PH_COMMAND ##1 st_r.phase == PH_IDLE);
  c_overrun: cover property (st_r.phase == PH_EXEC && xfer_abort && rd_valid);
  c_result:  cover property (st_r.phase == PH_RESULT ##[1:20] st_r.phase == PH_IDLE);
  c_dual:    cover property (io_rd_stb && io_addr == ADDR_INPUT_CTRL && reg_layout == LAYOUT_DUAL);

endmodule : floppy_host_register_port

// [engine_model.sv]
// Purpose: command engine model behind the host port
// Assumes: tasks are called one at a time
// Notes:   idle result data shows the inverted last byte
// **********
// engine model
// **********
module engine_model
  import floppy_port_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // command bytes
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  // result bytes
  input  wire logic       res_ready,
  output logic            res_valid,
  output logic [7:0]      res_data,
  // phase events
  output logic            cmd_end,
  output logic            cmd_has_exec,
  output logic            cmd_has_result,
  output logic            exec_end,
  output logic            xfer_overrun,
  output logic            result_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_cmd;
  // idle levels at time zero
  initial begin
    cmd_ready = 1'h1;
    res_valid = 1'h0;
    res_data = 8'hff;
    {cmd_end, cmd_has_exec, cmd_has_result} = 3'h0;
    {exec_end, xfer_overrun, result_end} = 3'h0;
  end
  // keep the byte taken, for the bench
  always_ff @(posedge mclk) begin
    if (cmd_valid && cmd_ready) last_cmd <= cmd_data;
  end
  // end of command bytes, with phase levels
  task automatic end_cmd(input logic ex, input logic rs);
    @(posedge mclk);
    {cmd_end, cmd_has_exec, cmd_has_result} <= {1'h1, ex, rs};
    @(posedge mclk);
    cmd_end <= 1'h0;
  endtask : end_cmd
  // push one byte, held until res_ready is seen high after an edge or for at most 50 cycles
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    res_valid <= 1'h1;
    res_data <= b;
    repeat (50) begin
      @(posedge mclk);
      if (res_ready) break;
    end
    res_valid <= 1'h0;
    res_data <= ~b; // no stale value once released
  endtask : send
  // one-cycle event: exec end, overrun, result end
  task automatic ev(input logic [2:0] k);
    @(posedge mclk);
    {exec_end, xfer_overrun, result_end} <= k;
    @(posedge mclk);
    {exec_end, xfer_overrun, result_end} <= 3'h0;
  endtask : ev
endmodule : engine_model

// [tb_top.sv]
// Purpose: self-checking bench of the host register port
// Assumes: engine model drives the core side
// Notes:   status is polled before each data byte
// **********
// bench top
// **********
module tb_top;
  import floppy_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, soft_rst, io_rd_stb, io_wr_stb, force_change;
  logic        dma_gate, media_changed_n, polled_mode, cmd_valid, cmd_ready;
  logic        res_valid, res_ready, cmd_end, cmd_has_exec, cmd_has_result;
  logic        exec_end, xfer_overrun, result_end, skip_write_comp;
  logic        density_out, xfer_abort, io_oe_lo, io_oe_hi;
  logic        fifo_enable_set, exec_dir_read;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, cmd_data, res_data, d;
  logic [3:0]  drive_seek_active;
  logic [1:0]  rate_select, oe;
  layout_t     reg_layout;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  floppy_host_register_port dut_u (.mclk, .rst, .soft_rst, .io_addr, .io_rd_stb,
    .io_wr_stb, .io_wdata, .io_rdata, .io_oe_lo, .io_oe_hi, .reg_layout,
    .force_change, .dma_gate, .media_changed_n, .drive_seek_active, .polled_mode,
    .fifo_enable_set, .cmd_end, .cmd_has_exec, .cmd_has_result,
    .exec_dir_read, .exec_end, .xfer_overrun, .result_end, .cmd_valid,
    .cmd_data, .cmd_ready, .res_valid, .res_data, .res_ready, .rate_select,
    .skip_write_comp, .density_out, .xfer_abort);
  engine_model eng_u (.mclk, .cmd_valid, .cmd_data, .cmd_ready, .res_ready,
    .res_valid, .res_data, .cmd_end, .cmd_has_exec, .cmd_has_result, .exec_end,
    .xfer_overrun, .result_end);
  // 50 MHz clock
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  // hang guard, the run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr8(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    {io_addr, io_wdata, io_wr_stb} <= {a, v, 1'h1};
    @(posedge mclk);
    io_wr_stb <= 1'h0;
  endtask : wr8
  // answer stands one cycle after the strobe edge
  task automatic rd8(input logic [15:0] a);
    @(posedge mclk);
    {io_addr, io_rd_stb} <= {a, 1'h1};
    @(posedge mclk);
    io_rd_stb <= 1'h0;
    #1;
    d = io_rdata;
    oe = {io_oe_hi, io_oe_lo};
  endtask : rd8
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] eo);
    rd8(a);
    chk(d, e);
    chk({6'h0, oe}, {6'h0, eo});
  endtask : rdchk
  // bounded status poll
  task automatic st(input logic [7:0] e);
    repeat (20) begin
      rd8(ADDR_STATUS_RATE);
      if (d === e) break;
    end
    chk(d, e);
  endtask : st
  task automatic lay(input layout_t x);
    @(posedge mclk);
    reg_layout <= x;
  endtask : lay
  task automatic done(input string s);
    $display("test %s done, mismatches %0d", s, n_mismatch);
  endtask : done
  // main sequence
  initial begin
    {rst, soft_rst, io_rd_stb, io_wr_stb, force_change} = 5'h10;
    {dma_gate, media_changed_n, polled_mode} = 3'h5;
    {fifo_enable_set, exec_dir_read} = 2'h1;
    {io_addr, io_wdata, drive_seek_active} = 28'h0;
    reg_layout = LAYOUT_AT;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    #1;
    chk({4'h0, skip_write_comp, density_out, rate_select}, 8'h06);
    done("reset");
    // let the low change pin through the three-stage synchroniser
    repeat (3) @(posedge mclk);
    lay(LAYOUT_DUAL);
    rdchk(ADDR_INPUT_CTRL, 8'hfd, 2'h3);
    lay(LAYOUT_M30);
    rdchk(ADDR_INPUT_CTRL, 8'h8a, 2'h3);
    wr8(ADDR_INPUT_CTRL, 8'h07);
    rdchk(ADDR_INPUT_CTRL, 8'h8f, 2'h3);
    @(posedge mclk);
    dma_gate <= 1'h0;
    rdchk(ADDR_INPUT_CTRL, 8'h87, 2'h3);
    wr8(ADDR_STATUS_RATE, 8'h01);
    lay(LAYOUT_DUAL);
    rdchk(ADDR_INPUT_CTRL, 8'hfb, 2'h3);
    @(posedge mclk);
    soft_rst <= 1'h1;
    @(posedge mclk);
    soft_rst <= 1'h0;
    #1;
    chk({4'h0, skip_write_comp, density_out, rate_select}, 8'h09);
    rdchk(16'h03f6, 8'h00, 2'h0);
    lay(LAYOUT_AT);
    media_changed_n <= 1'h1;
    repeat (4) @(posedge mclk);
    rd8(ADDR_INPUT_CTRL);
    chk({d[7], 5'h0, oe}, 8'h02);
    @(posedge mclk);
    force_change <= 1'h1;
    rd8(ADDR_INPUT_CTRL);
    chk({d[7], 5'h0, oe}, 8'h82);
    done("ports");
    @(posedge mclk);
    drive_seek_active <= 4'h9;
    st(8'h89);
    @(posedge mclk);
    drive_seek_active <= 4'h0;
    st(8'h80);
    wr8(ADDR_DATA, 8'h0f);
    st(8'h90);
    chk(eng_u.last_cmd, 8'h0f);
    eng_u.end_cmd(1'h0, 1'h0);
    st(8'h80);
    done("seek");
    wr8(ADDR_DATA, 8'he6);
    st(8'h90);
    eng_u.end_cmd(1'h1, 1'h1);
    st(8'h70);
    eng_u.send(8'h3c);
    st(8'hf0);
    rdchk(ADDR_DATA, 8'h3c, 2'h3);
    eng_u.send(8'h5a);
    eng_u.ev(3'h2);
    #1;
    chk({7'h0, xfer_abort}, 8'h01);
    st(8'hf0);
    rdchk(ADDR_DATA, 8'h5a, 2'h3);
    eng_u.ev(3'h4);
    #1;
    chk({7'h0, xfer_abort}, 8'h00);
    eng_u.send(8'hc0);
    eng_u.ev(3'h1);
    st(8'hd0);
    rdchk(ADDR_DATA, 8'hc0, 2'h3);
    st(8'h80);
    done("read");
    // disk write with fifo on, not polled, then an underrun
    @(posedge mclk);
    {exec_dir_read, polled_mode, fifo_enable_set} <= 3'h1;
    @(posedge mclk);
    fifo_enable_set <= 1'h0;
    wr8(ADDR_DATA, 8'hc5);
    st(8'h90);
    eng_u.end_cmd(1'h1, 1'h0);
    st(8'h90);
    wr8(ADDR_DATA, 8'h11);
    st(8'h90);
    wr8(ADDR_DATA, 8'h22);
    st(8'h90);
    chk(eng_u.last_cmd, 8'h22);
    eng_u.ev(3'h2);
    #1;
    chk({7'h0, xfer_abort}, 8'h01);
    st(8'h10);
    eng_u.ev(3'h4);
    eng_u.ev(3'h1);
    st(8'h80);
    done("write");
    print_verdict();
  end
endmodule : tb_top
